// file: hall_motor_pkg.sv
package hall_motor_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ  = 250;
	localparam int TICK_MS  = 1;
	localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000;
	localparam int DEAD_NS  = 2000;
	localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int PWM_KHZ  = 20;
	localparam int PWM_CYC  = CLK_MHZ * 1000 / PWM_KHZ;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_DUTY     = 8'h04;
	localparam logic [7:0] A_DEAD     = 8'h08;
	localparam logic [7:0] A_ADC_CMD  = 8'h0c;
	localparam logic [7:0] A_ADC_SPD  = 8'h10;
	localparam logic [7:0] A_ADC_VBUS = 8'h14;
	localparam logic [7:0] A_SPD_CAP  = 8'h18;
	localparam logic [7:0] A_SPD_CNT  = 8'h1c;
	localparam logic [7:0] A_POS      = 8'h20;
	localparam logic [7:0] A_IRQ_STAT = 8'h24;
	localparam logic [7:0] A_IRQ_MASK = 8'h28;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_COMP  = 1;
	localparam int CTRL_CLR   = 2;
	localparam int CTRL_REV   = 3;
	localparam int ADC_CHAN   = 0;
	localparam int ADC_START  = 1;
	localparam int IRQ_TICK   = 0;
	localparam int IRQ_HALL   = 1;
	localparam int IRQ_ADC    = 2;
	localparam int IRQ_OC     = 3;
	localparam int IRQ_POS    = 4;
	localparam int IRQ_W      = 5;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [15:0] DEAD_RST = 16'(DEAD_CYC);
	localparam logic        CH_SPEED = 1'b0;
	localparam logic        CH_VBUS  = 1'b1;

endpackage

// file: pin_sync.sv
`timescale 1ns/100ps
module pin_sync
	import hall_motor_pkg::*;
#(
	parameter int W = 4
)(
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] edge_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] edg;
	} sync_t;

	sync_t sync_reg;
	sync_t sync_next;

	// A level change counts only once the second and third stages agree
	always_comb
	begin
		sync_next     = sync_reg;
		sync_next.s1  = pin_i;
		sync_next.s2  = sync_reg.s1;
		sync_next.s3  = sync_reg.s2;
		sync_next.lvl = (sync_reg.s2 & sync_reg.s3)
			| (sync_reg.lvl & (sync_reg.s2 | sync_reg.s3));
		sync_next.edg = sync_next.lvl ^ sync_reg.lvl;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			sync_reg <= '0;
		else
			sync_reg <= sync_next;
	end

	assign level_o = sync_reg.lvl;
	assign edge_o  = sync_reg.edg;

endmodule

// file: hall_commutation_pwm_controller.sv
`timescale 1ns/100ps
module hall_commutation_pwm_controller
	import hall_motor_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int PWM_CYCLES  = PWM_CYC,
	parameter int CNT_W       = 16,
	parameter int ADC_W       = 12
)(
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	input  wire logic [7:0]       addr_i,
	input  wire logic [31:0]      wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic      [31:0]      rdata_o,
	output logic                  irq_o,
	input  wire logic             hall_u_edge_input_i,
	input  wire logic             hall_v_edge_input_i,
	input  wire logic             hall_w_edge_input_i,
	input  wire logic             overcurrent_stop_input_i,
	output logic      [2:0]       gate_hi_o,
	output logic      [2:0]       gate_hi_oe_o,
	output logic      [2:0]       gate_lo_o,
	output logic      [2:0]       gate_lo_oe_o,
	output logic                  adc_start_o,
	output logic                  adc_chan_o,
	input  wire logic             adc_done_i,
	input  wire logic [ADC_W-1:0] adc_data_i
);

	// Tick counter width follows the configured period; the carrier counter is fixed at 16 bits
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam logic [15:0]   PWM_LAST  = 16'(PWM_CYCLES - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		// Control and timing
		logic             run;
		logic             comp;
		logic             rev;
		logic [15:0]      duty;
		logic [15:0]      dead;
		logic [15:0]      duty_act;
		logic [15:0]      pwm_cnt;
		logic             pwm_on;
		logic [15:0]      dead_cnt;
		logic [TW-1:0]    tick_cnt;
		// Speed measurement
		logic [CNT_W-1:0] spd_cnt;
		logic [CNT_W-1:0] spd_last;
		logic [CNT_W-1:0] spd_cap;
		// Commutation and protection
		logic [2:0]       hi;
		logic [2:0]       lo;
		logic             chop_hi;
		logic             pos_err;
		logic             trip;
		// Sampler and interrupts
		logic             adc_busy;
		logic             adc_chan;
		logic             adc_start;
		logic [ADC_W-1:0] adc_spd;
		logic [ADC_W-1:0] adc_vbus;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic             irq;
		// Bus and output flops
		logic [31:0]      rdata;
		logic [2:0]       gh;
		logic [2:0]       gl;
		logic             oe;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic [3:0] pin_lvl;
	logic [3:0] pin_edge;
	logic [2:0] hall_code;
	logic       hall_ev;
	logic       oc_lvl;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Overcurrent shares the synchroniser so its latency matches the Halls
	pin_sync #(
		.W (4)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.pin_i     ({overcurrent_stop_input_i, hall_w_edge_input_i,
		              hall_v_edge_input_i, hall_u_edge_input_i}),
		.level_o   (pin_lvl),
		.edge_o    (pin_edge)
	);

	assign hall_code = pin_lvl[2:0];
	assign hall_ev   = |pin_edge[2:0];
	assign oc_lvl    = pin_lvl[3];

	// ----------------------------------------------------------------
	// Hall code to conduction pattern
	// ----------------------------------------------------------------
	// Returns {high-side phase, low-side phase}, one-hot {w,v,u}
	function automatic logic [5:0] commute(input logic [2:0] code, input logic rev);
		logic [5:0] p;
		p = 6'h00;
		unique case (code)
			3'b001: p = {3'b001, 3'b100};
			3'b011: p = {3'b010, 3'b100};
			3'b010: p = {3'b010, 3'b001};
			3'b110: p = {3'b100, 3'b001};
			3'b100: p = {3'b100, 3'b010};
			3'b101: p = {3'b001, 3'b010};
			default: p = 6'h00;
		endcase
		if (rev)
			p = {p[2:0], p[5:3]};
		return p;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [5:0]  pat;
		logic        dead_ok;
		logic        arm_on;
		logic        arm_off;
		logic [2:0]  g_hi;
		logic [2:0]  g_lo;
		logic [31:0] rd_val;
		pat     = commute(hall_code, st_reg.rev);
		dead_ok = 1'b0;
		arm_on  = 1'b0;
		arm_off = 1'b0;
		g_hi    = 3'b000;
		g_lo    = 3'b000;
		rd_val  = 32'h0000_0000;
		st_next = st_reg;

		st_next.adc_start = 1'b0;

		// Register writes; status clear comes before event sets
		if (wr_i)
		begin
			unique case (addr_i)
				A_CTRL:
				begin
					st_next.run  = wdata_i[CTRL_RUN];
					st_next.comp = wdata_i[CTRL_COMP];
					st_next.rev  = wdata_i[CTRL_REV];
					if (wdata_i[CTRL_CLR] && !oc_lvl)
						st_next.trip = 1'b0;
				end
				A_DUTY:     st_next.duty = wdata_i[15:0];
				A_DEAD:     st_next.dead = wdata_i[15:0];
				A_IRQ_STAT: st_next.stat = st_reg.stat & ~wdata_i[IRQ_W-1:0];
				A_IRQ_MASK: st_next.mask = wdata_i[IRQ_W-1:0];
				A_ADC_CMD:
				begin
					if (wdata_i[ADC_START] && !st_reg.adc_busy)
					begin
						st_next.adc_start = 1'b1;
						st_next.adc_busy  = 1'b1;
						st_next.adc_chan  = wdata_i[ADC_CHAN];
					end
				end
				default: ;
			endcase
		end

		// Conversion result, stored by channel
		if (adc_done_i && st_reg.adc_busy)
		begin
			st_next.adc_busy      = 1'b0;
			st_next.stat[IRQ_ADC] = 1'b1;
			if (st_reg.adc_chan == CH_VBUS)
				st_next.adc_vbus = adc_data_i;
			else
				st_next.adc_spd = adc_data_i;
		end

		// Control tick
		if (st_reg.tick_cnt == TICK_LAST)
		begin
			st_next.tick_cnt       = '0;
			st_next.stat[IRQ_TICK] = 1'b1;
		end
		else
			st_next.tick_cnt = st_reg.tick_cnt + 1'b1;

		// Free-running speed counter, no event of its own
		st_next.spd_cnt = st_reg.spd_cnt + 1'b1;

		// Hall event: capture speed, new pattern, new duty
		// A bad code still refreshes the pattern so the gates go dark
		if (hall_ev)
		begin
			st_next.spd_cap        = st_reg.spd_cnt - st_reg.spd_last;
			st_next.spd_last       = st_reg.spd_cnt;
			st_next.chop_hi        = (pat[5:3] != st_reg.hi);
			st_next.hi             = pat[5:3];
			st_next.lo             = pat[2:0];
			st_next.duty_act       = st_reg.duty;
			st_next.pos_err        = (pat == 6'h00);
			st_next.stat[IRQ_HALL] = 1'b1;
			if (pat == 6'h00)
				st_next.stat[IRQ_POS] = 1'b1;
		end

		// Overcurrent latch; the pin level wins over a clear
		if (oc_lvl)
		begin
			st_next.trip         = 1'b1;
			st_next.stat[IRQ_OC] = 1'b1;
		end

		// Carrier and dead time
		if (st_reg.pwm_cnt == PWM_LAST)
			st_next.pwm_cnt = 16'h0000;
		else
			st_next.pwm_cnt = st_reg.pwm_cnt + 16'h0001;
		st_next.pwm_on = (st_reg.pwm_cnt < st_reg.duty_act);
		if (st_next.pwm_on != st_reg.pwm_on)
			st_next.dead_cnt = st_reg.dead;
		else if (st_reg.dead_cnt != 16'h0000)
			st_next.dead_cnt = st_reg.dead_cnt - 16'h0001;

		// Only the arm that just began conducting is chopped
		dead_ok = !st_reg.comp || (st_reg.dead_cnt == 16'h0000);
		arm_on  = st_reg.pwm_on && dead_ok;
		arm_off = st_reg.comp && !st_reg.pwm_on && dead_ok;
		if (st_reg.chop_hi)
		begin
			g_hi = st_reg.hi & {3{arm_on}};
			g_lo = st_reg.lo | (st_reg.hi & {3{arm_off}});
		end
		else
		begin
			g_lo = st_reg.lo & {3{arm_on}};
			g_hi = st_reg.hi | (st_reg.lo & {3{arm_off}});
		end
		// A trip in this cycle blanks the gates on the same edge as the cutoff
		if (!st_reg.run || st_reg.pos_err || st_next.trip)
		begin
			g_hi = 3'b000;
			g_lo = 3'b000;
		end
		st_next.gh = g_hi;
		st_next.gl = g_lo;
		st_next.oe = !st_next.trip;

		// Read data stand only in the cycle after the strobe
		unique case (addr_i)
			A_CTRL:
			begin
				rd_val[CTRL_RUN]  = st_reg.run;
				rd_val[CTRL_COMP] = st_reg.comp;
				rd_val[CTRL_REV]  = st_reg.rev;
			end
			A_DUTY:     rd_val[15:0] = st_reg.duty;
			A_DEAD:     rd_val[15:0] = st_reg.dead;
			A_ADC_CMD:
			begin
				rd_val[ADC_CHAN]  = st_reg.adc_chan;
				rd_val[ADC_START] = st_reg.adc_busy;
			end
			A_ADC_SPD:  rd_val[ADC_W-1:0] = st_reg.adc_spd;
			A_ADC_VBUS: rd_val[ADC_W-1:0] = st_reg.adc_vbus;
			A_SPD_CAP:  rd_val[CNT_W-1:0] = st_reg.spd_cap;
			A_SPD_CNT:  rd_val[CNT_W-1:0] = st_reg.spd_cnt;
			A_POS:
			begin
				rd_val[2:0]  = hall_code;
				rd_val[6:4]  = st_reg.hi;
				rd_val[10:8] = st_reg.lo;
				rd_val[12]   = st_reg.pos_err;
				rd_val[13]   = st_reg.trip;
			end
			A_IRQ_STAT: rd_val[IRQ_W-1:0] = st_reg.stat;
			A_IRQ_MASK: rd_val[IRQ_W-1:0] = st_reg.mask;
			default:    rd_val = 32'h0000_0000;
		endcase
		st_next.rdata = rd_i ? rd_val : 32'h0000_0000;

		st_next.irq = |(st_next.stat & st_next.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Duty and dead time leave reset at their own defaults
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg      <= '0;
			st_reg.duty <= DUTY_RST;
			st_reg.dead <= DEAD_RST;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_o      = st_reg.rdata;
	assign irq_o        = st_reg.irq;
	assign gate_hi_o    = st_reg.gh;
	assign gate_lo_o    = st_reg.gl;
	// Both enables come from one flop so all arms float together
	assign gate_hi_oe_o = {3{st_reg.oe}};
	assign gate_lo_oe_o = {3{st_reg.oe}};
	assign adc_start_o  = st_reg.adc_start;
	assign adc_chan_o   = st_reg.adc_chan;

endmodule

// file: hall_commutation_pwm_controller_chk.sv
`timescale 1ns/100ps
module hall_commutation_pwm_controller_chk
	import hall_motor_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        hall_u_edge_input_i,
	input  wire logic        hall_v_edge_input_i,
	input  wire logic        hall_w_edge_input_i,
	input  wire logic        overcurrent_stop_input_i,
	input  wire logic [2:0]  gate_hi_o,
	input  wire logic [2:0]  gate_hi_oe_o,
	input  wire logic [2:0]  gate_lo_o,
	input  wire logic [2:0]  gate_lo_oe_o,
	input  wire logic        adc_start_o,
	input  wire logic        adc_chan_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire same_hall = (hall_u_edge_input_i == hall_v_edge_input_i)
		&& (hall_v_edge_input_i == hall_w_edge_input_i);
	oc_cutoff_a: assert property (overcurrent_stop_input_i [*6] |=>
		gate_hi_oe_o == 3'h0 && gate_lo_oe_o == 3'h0) else $error("gates still driven");
	oe_pair_a: assert property (gate_hi_oe_o == gate_lo_oe_o
		&& (gate_hi_oe_o == 3'h0 || gate_hi_oe_o == 3'h7)) else $error("enables split");
	cut_quiet_a: assert property (gate_hi_oe_o == 3'h0 |->
		gate_hi_o == 3'h0 && gate_lo_o == 3'h0) else $error("cut gates not zero");
	no_shoot_a: assert property ((gate_hi_o & gate_lo_o) == 3'h0)
		else $error("both arms on");
	adc_sw_a: assert property (adc_start_o |->
		$past(wr_i && addr_i == A_ADC_CMD && wdata_i[ADC_START])) else $error("start no write");
	adc_chan_a: assert property (adc_start_o |->
		adc_chan_o == $past(wdata_i[ADC_CHAN])) else $error("wrong channel");
	adc_single_a: assert property (adc_start_o |=> !adc_start_o)
		else $error("start too long");
	pos_err_off_a: assert property (same_hall [*8] |->
		gate_hi_o == 3'h0 && gate_lo_o == 3'h0) else $error("gates on at bad hall");
	cover property (adc_start_o && adc_chan_o);
	cover property (overcurrent_stop_input_i [*6] ##1 gate_hi_oe_o == 3'h0);
	cover property (gate_hi_o != 3'h0 && gate_lo_o != 3'h0);
endmodule

// file: motor_far_side.sv
`timescale 1ns/100ps
module motor_far_side
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  dly_i,
	input  wire logic [11:0] val_i,
	input  wire logic        fault_i,
	output logic             oc_o,
	output logic             done_o,
	output logic      [11:0] data_o
);
	logic [7:0]  cnt;
	logic        busy;
	logic [11:0] last;
	// Overcurrent comparator outside the device
	assign oc_o = fault_i;
	// Released data line shows the inverse of the last result
	assign data_o = done_o ? last : ~last;
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy <= 1'b0;
			cnt <= 8'h00;
			done_o <= 1'b0;
			last <= 12'h000;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i)
			begin
				busy <= 1'b1;
				cnt <= dly_i;
			end
			else if (busy && cnt == 8'h00)
			begin
				busy <= 1'b0;
				done_o <= 1'b1;
				last <= val_i;
			end
			else if (busy)
				cnt <= cnt - 8'h01;
		end
	end
endmodule

// file: hall_commutation_pwm_controller_tb.sv
`timescale 1ns/100ps
module hall_commutation_pwm_controller_tb;
	import hall_motor_pkg::*;
	localparam int TK = 50;
	localparam int HS = 20;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [2:0]  hall = 3'h0;
	logic        fault = 1'b0;
	logic [7:0]  dly = 8'h02;
	logic [11:0] val = 12'h000;
	logic [31:0] rdata, r;
	logic [2:0]  ghi, ghoe, glo, gloe;
	logic [11:0] adata;
	logic        irq, oc, ast, ach, adone;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          t0;
	int          hi_t[8] = '{0, 1, 2, 2, 4, 1, 4, 0};
	int          lo_t[8] = '{0, 4, 1, 4, 2, 2, 1, 0};
	int          seq[$] = '{1, 3, 2, 6, 4, 5};
	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	hall_commutation_pwm_controller #(.TICK_CYCLES(TK), .PWM_CYCLES(40))
		hall_commutation_pwm_controller_inst (.clk_sys_i(clk), .rst_i(rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq),
		.hall_u_edge_input_i(hall[0]), .hall_v_edge_input_i(hall[1]),
		.hall_w_edge_input_i(hall[2]), .overcurrent_stop_input_i(oc), .gate_hi_o(ghi),
		.gate_hi_oe_o(ghoe), .gate_lo_o(glo), .gate_lo_oe_o(gloe), .adc_start_o(ast),
		.adc_chan_o(ach), .adc_done_i(adone), .adc_data_i(adata));
	motor_far_side motor_far_side_inst (.clk_sys_i(clk), .rst_i(rst), .start_i(ast),
		.dly_i(dly), .val_i(val), .fault_i(fault), .oc_o(oc), .done_o(adone), .data_o(adata));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 r = rdata;
	endtask
	task automatic hall_set(input int c);
		@(posedge clk);
		hall <= 3'(c);
		repeat (HS) @(posedge clk);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		@(negedge clk);
		while (irq !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 200)
		begin
			num_errors++;
			report_and_stop;
		end
	endtask
	initial
	begin
		r = $urandom(21309);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(32'(ghoe), 32'h7);
		wr(A_IRQ_MASK, 32'h1f);
		wr(8'hfc, 32'hffffffff);
		rd(A_IRQ_MASK);
		chk(r, 32'h1f);
		rd(8'hfc);
		chk(r, 32'h0);
		rd(A_SPD_CNT);
		t0 = int'(r);
		rd(A_SPD_CNT);
		chk(r, (t0 + 2) & 32'hffff);
		wr(A_IRQ_MASK, 32'h0);
		repeat (TK + 5) @(posedge clk);
		#1 chk(32'(irq), 32'h0);
		rd(A_IRQ_STAT);
		chk(r & 32'h1, 32'h1);
		wr(A_IRQ_MASK, 32'h1);
		wait_irq;
		wr(A_IRQ_STAT, 32'h1f);
		wait_irq;
		t0 = cyc;
		wr(A_IRQ_STAT, 32'h1f);
		wait_irq;
		chk(cyc - t0, TK);
		wr(A_IRQ_MASK, 32'h0);
		for (int ch = 0; ch < 2; ch++)
		begin
			val <= 12'($urandom);
			dly <= ch ? 8'h1e : 8'h02;
			wr(A_ADC_CMD, 32'(2 + ch));
			wr(A_ADC_CMD, 32'(2 + ch));
			r = 32'h2;
			for (int n = 0; n < 40 && r[1] !== 1'b0; n++)
				rd(A_ADC_CMD);
			chk(r & 32'h3, 32'(ch));
			rd(ch ? A_ADC_VBUS : A_ADC_SPD);
			chk(r, 32'(val));
		end
		wr(A_DEAD, 32'h8);
		wr(A_DUTY, 32'h28);
		wr(A_CTRL, 32'h1);
		foreach (seq[i])
		begin
			hall_set(seq[i]);
			rd(A_POS);
			chk(r & 32'h777, 32'(seq[i] | hi_t[seq[i]] << 4 | lo_t[seq[i]] << 8));
			chk(32'({glo, ghi}), 32'(lo_t[seq[i]] << 3 | hi_t[seq[i]]));
		end
		for (int m = 0; m < 2; m++)
		begin
			wr(A_CTRL, 32'(1 | m << 1));
			wr(A_DUTY, 32'h0);
			#1 chk(32'({glo, ghi}), m ? 32'h14 : 32'h11);
			hall_set(1);
			hall_set(3);
			chk(32'({glo, ghi}), m ? 32'h30 : 32'h20);
			rd(A_SPD_CAP);
			chk(r & 32'hffff, HS + 1);
			wr(A_IRQ_STAT, 32'h1f);
			hall_set(m ? 7 : 0);
			rd(A_IRQ_STAT);
			chk(r & 32'h10, 32'h10);
			hall_set(5);
			wr(A_DUTY, 32'h28);
			hall_set(4);
		end
		wr(A_DUTY, 32'($urandom_range(5, 35)));
		foreach (seq[i])
			hall_set(seq[i]);
		fault <= 1'b1;
		repeat (10) @(posedge clk);
		#1 chk(32'({ghoe, gloe, ghi, glo}), 32'h0);
		wr(A_CTRL, 32'h7);
		fault <= 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(32'(ghoe), 32'h0);
		rd(A_IRQ_STAT);
		chk(r & 32'h8, 32'h8);
		wr(A_CTRL, 32'h7);
		repeat (3) @(posedge clk);
		#1 chk(32'(ghoe), 32'h7);
		report_and_stop;
	end
endmodule
bind hall_commutation_pwm_controller hall_commutation_pwm_controller_chk chk_inst (.clk_sys_i,
	.rst_i, .addr_i, .wdata_i, .wr_i, .hall_u_edge_input_i, .hall_v_edge_input_i,
	.hall_w_edge_input_i, .overcurrent_stop_input_i, .gate_hi_o, .gate_hi_oe_o, .gate_lo_o,
	.gate_lo_oe_o, .adc_start_o, .adc_chan_o);
